//--- hdl/edge_detect.sv
// Edge detector for the external interrupt pins.
// Assumes pins are already synchronous and noise filtered.
`timescale 1ns/1ps
module edge_detect
  import pwr_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Pins
  input  wire logic [NUM_EXT_INT-1:0] pins_i,
  output logic      [NUM_EXT_INT-1:0] edge_o
);

  logic [NUM_EXT_INT-1:0] prev_r;
  logic [NUM_EXT_INT-1:0] prev_nxt;
  logic [NUM_EXT_INT-1:0] edge_r;
  logic [NUM_EXT_INT-1:0] edge_nxt;

  always_comb begin
    prev_nxt = pins_i;
    edge_nxt = pins_i ^ prev_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_r <= pins_i;
      edge_r <= '0;
    end else begin
      prev_r <= prev_nxt;
      edge_r <= edge_nxt;
    end
  end

  assign edge_o = edge_r;

endmodule

//--- hdl/pwr_ctrl.sv
// Stop and idle power-down sequencer with its control registers.
// Assumes the CPU presents each executed opcode as a one-cycle strobe.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// How it works
// - Opcode 7F enters stop mode only when the stop key register holds A5.
// - Stop mode turns off the main oscillator, freezing CPU and peripherals.
// - Data registers keep their values through stop mode.
// - Reset ends stop, restores control registers, keeps data registers.
// - Reset clears clock divider bits 4:3 to slow clock.
// - After reset release wait stabilization, then fetch from 0100.
// - Edges on twelve external interrupt pins release stop mode.
// - Interrupt release keeps control registers except the stop key.
// - Interrupt release keeps the clock divider selection.
// - Interrupt release services the interrupt then resumes after stop.
// - Enabled internal interrupts release stop like external ones.
// - Opcode 6F gates the CPU clock, peripherals keep running.
// - Port directions are held during idle mode.
// - Reset ends idle, restores controls, keeps data, slow clock.
// - With all interrupts masked only reset ends idle.
// - Enabled interrupt ends idle, clock kept, serviced, resume after idle.
module pwr_ctrl
  import pwr_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Register port
  input  wire logic [7:0]             reg_addr_i,
  input  wire logic [7:0]             reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic      [7:0]             reg_rdata_o,
  // CPU core
  input  wire logic [7:0]             opcode_i,
  input  wire logic                   opcode_valid_i,
  input  wire logic                   return_from_interrupt_i,
  input  wire logic [7:0]             port_dir_i,
  // Interrupt sources
  input  wire logic [NUM_EXT_INT-1:0] external_interrupt_lines_i,
  input  wire logic [NUM_EXT_INT-1:0] ext_int_enable_i,
  input  wire logic                   internal_irq_i,
  input  wire logic                   global_int_enable_i,
  // Controls
  output logic                        osc_en_o,
  output logic                        cpu_clk_en_o,
  output logic                        periph_clk_en_o,
  output logic                        service_irq_o,
  output logic                        fetch_reset_o,
  output logic      [15:0]            fetch_addr_o,
  output logic      [1:0]             clk_div_sel_o,
  output logic      [7:0]             port_dir_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg_req_t               req;
  pwr_state_t             state_r;
  pwr_state_t             state_nxt;
  pwr_ctl_t               ctl_r;
  pwr_ctl_t               ctl_nxt;
  logic [7:0]             btctl_r;
  logic [7:0]             btctl_nxt;
  logic [7:0]             clkctl_r;
  logic [7:0]             clkctl_nxt;
  logic [7:0]             stpkey_r;
  logic [7:0]             stpkey_nxt;
  logic [7:0]             data_r;
  logic [7:0]             data_nxt;
  logic [7:0]             rdata_r;
  logic [7:0]             rdata_nxt;
  logic [7:0]             dir_r;
  logic [7:0]             dir_nxt;
  logic [STAB_MSB:0]      stab_r;
  logic [STAB_MSB:0]      stab_nxt;
  logic                   from_reset_r;
  logic                   from_reset_nxt;
  logic [15:0]            fetch_r;
  logic [15:0]            fetch_nxt;
  logic [NUM_EXT_INT-1:0] ext_edge;
  logic                   wake_irq;
  logic                   do_stop;
  logic                   do_idle;

  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  edge_detect u_edge (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pins_i (external_interrupt_lines_i),
    .edge_o (ext_edge)
  );

  // ----------------------------------------------------------------
  // Wake and entry decode
  // ----------------------------------------------------------------
  always_comb begin
    wake_irq = global_int_enable_i & ((|(ext_edge & ext_int_enable_i)) | internal_irq_i);
    do_stop  = opcode_valid_i & (opcode_i == OPC_STOP) & (stpkey_r == STOP_KEY);
    do_idle  = opcode_valid_i & (opcode_i == OPC_IDLE);
  end

  // ----------------------------------------------------------------
  // Registers and sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt      = state_r;
    ctl_nxt        = ctl_r;
    btctl_nxt      = btctl_r;
    clkctl_nxt     = clkctl_r;
    stpkey_nxt     = stpkey_r;
    data_nxt       = data_r;
    dir_nxt        = dir_r;
    stab_nxt       = stab_r;
    from_reset_nxt = from_reset_r;
    fetch_nxt      = fetch_r;
    rdata_nxt      = ZERO8;
    ctl_nxt.service_irq = 1'b0;
    ctl_nxt.fetch_reset = 1'b0;
    if (state_r == ST_RUN) begin
      dir_nxt = port_dir_i;
    end
    if (req.wr && (state_r == ST_RUN)) begin
      case (req.addr)
        ADDR_BTCTL:  btctl_nxt  = req.wdata;
        ADDR_CLKCTL: clkctl_nxt = req.wdata;
        ADDR_STPKEY: stpkey_nxt = req.wdata;
        ADDR_DATA:   data_nxt   = req.wdata;
        default:     data_nxt   = data_r;
      endcase
    end
    if (req.rd) begin
      case (req.addr)
        ADDR_BTCTL:  rdata_nxt = btctl_r;
        ADDR_CLKCTL: rdata_nxt = clkctl_r;
        ADDR_STPKEY: rdata_nxt = stpkey_r;
        ADDR_DATA:   rdata_nxt = data_r;
        ADDR_STATUS: rdata_nxt = {3'h0, state_r};
        default:     rdata_nxt = ZERO8;
      endcase
    end
    case (state_r)
      ST_RUN: begin
        if (do_stop) begin
          state_nxt             = ST_STOP;
          ctl_nxt.osc_en        = 1'b0;
          ctl_nxt.cpu_clk_en    = 1'b0;
          ctl_nxt.periph_clk_en = 1'b0;
        end else if (do_idle) begin
          state_nxt          = ST_IDLE;
          ctl_nxt.cpu_clk_en = 1'b0;
        end
      end
      ST_STOP: begin
        if (wake_irq) begin
          state_nxt      = ST_STAB;
          stpkey_nxt     = STPKEY_RST;
          from_reset_nxt = 1'b0;
          stab_nxt       = STAB_ZERO;
          ctl_nxt.osc_en = 1'b1;
        end
      end
      ST_IDLE: begin
        if (wake_irq) begin
          state_nxt           = ST_RUN;
          ctl_nxt.cpu_clk_en  = 1'b1;
          ctl_nxt.service_irq = 1'b1;
        end
      end
      ST_STAB: begin
        stab_nxt = stab_r + STAB_ONE;
        if (stab_r >= stab_limit(btctl_r[2:0])) begin
          state_nxt             = ST_RUN;
          ctl_nxt.cpu_clk_en    = 1'b1;
          ctl_nxt.periph_clk_en = 1'b1;
          if (from_reset_r) begin
            ctl_nxt.fetch_reset = 1'b1;
            fetch_nxt           = RESET_VECTOR;
          end else begin
            ctl_nxt.service_irq = 1'b1;
          end
        end
      end
      ST_RST_WAIT: begin
        state_nxt      = ST_STAB;
        from_reset_nxt = 1'b1;
        stab_nxt       = STAB_ZERO;
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r      <= ST_RST_WAIT;
      ctl_r        <= '{osc_en: 1'b1, cpu_clk_en: 1'b0, periph_clk_en: 1'b0,
                        service_irq: 1'b0, fetch_reset: 1'b0};
      btctl_r      <= BTCTL_RST;
      clkctl_r     <= CLKCTL_RST;
      stpkey_r     <= STPKEY_RST;
      dir_r        <= DIR_RST;
      stab_r       <= STAB_ZERO;
      from_reset_r <= 1'b1;
      fetch_r      <= RESET_VECTOR;
      rdata_r      <= ZERO8;
    end else begin
      state_r      <= state_nxt;
      ctl_r        <= ctl_nxt;
      btctl_r      <= btctl_nxt;
      clkctl_r     <= clkctl_nxt;
      stpkey_r     <= stpkey_nxt;
      dir_r        <= dir_nxt;
      stab_r       <= stab_nxt;
      from_reset_r <= from_reset_nxt;
      fetch_r      <= fetch_nxt;
      rdata_r      <= rdata_nxt;
    end
  end

  // Data register is not reset so its contents survive reset and stop.
  always_ff @(posedge clk_i) begin
    data_r <= data_nxt;
  end

  assign reg_rdata_o     = rdata_r;
  assign osc_en_o        = ctl_r.osc_en;
  assign cpu_clk_en_o    = ctl_r.cpu_clk_en;
  assign periph_clk_en_o = ctl_r.periph_clk_en;
  assign service_irq_o   = ctl_r.service_irq;
  assign fetch_reset_o   = ctl_r.fetch_reset;
  assign fetch_addr_o    = fetch_r;
  assign clk_div_sel_o   = clkctl_r[CLKDIV_MSB:CLKDIV_LSB];
  assign port_dir_o      = dir_r;

endmodule

//--- hdl/pwr_ctrl_pkg.sv
// Constants and types for the stop and idle power-down controller.
// Assumes a 20 MHz system clock and an 8-bit register port.
package pwr_ctrl_pkg;

  // ----------------------------------------------------------------
  // Opcodes and key
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_STOP      = 8'h7F;
  localparam logic [7:0] OPC_IDLE      = 8'h6F;
  localparam logic [7:0] STOP_KEY      = 8'hA5;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_BTCTL    = 8'hD3;
  localparam logic [7:0] ADDR_CLKCTL   = 8'hD4;
  localparam logic [7:0] ADDR_STATUS   = 8'hD5;
  localparam logic [7:0] ADDR_DATA     = 8'hD6;
  localparam logic [7:0] ADDR_STPKEY   = 8'hFB;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int         CLKDIV_LSB    = 3;
  localparam int         CLKDIV_MSB    = 4;
  localparam logic [1:0] CLKDIV_SLOW   = 2'h0;
  localparam logic [7:0] BTCTL_RST     = 8'h00;
  localparam logic [7:0] CLKCTL_RST    = 8'h00;
  localparam logic [7:0] STPKEY_RST    = 8'h00;
  localparam logic [7:0] DIR_RST       = 8'h00;
  localparam logic [7:0] ZERO8         = 8'h00;
  localparam logic [15:0] RESET_VECTOR = 16'h0100;
  localparam int         NUM_EXT_INT   = 12;
  localparam int         STAB_MSB      = 11;
  localparam logic [11:0] STAB_ZERO    = 12'h000;
  localparam logic [11:0] STAB_ONE     = 12'h001;
  localparam logic [7:0] STAB_SHIFT_ONE = 8'h01;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_RUN     = 5'h01,
    ST_STOP    = 5'h02,
    ST_IDLE    = 5'h04,
    ST_STAB    = 5'h08,
    ST_RST_WAIT = 5'h10
  } pwr_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic       osc_en;
    logic       cpu_clk_en;
    logic       periph_clk_en;
    logic       service_irq;
    logic       fetch_reset;
  } pwr_ctl_t;

  function automatic logic [11:0] stab_limit(input logic [2:0] sel);
    stab_limit = STAB_ONE << sel;
  endfunction

endpackage

//--- tb/cpu_model.sv
// CPU core and interrupt source model for the power-down sequencer.
// Assumes its tasks are called from one bench process.
`timescale 1ns/1ps
module cpu_model
  import pwr_ctrl_pkg::*;
#(
  parameter logic [7:0] OPC_NOP = 8'hFF
)(
  // Clock
  input  wire logic                   clk_i,
  // CPU and interrupt side
  output logic      [7:0]             opcode_o,
  output logic                        opcode_valid_o,
  output logic      [NUM_EXT_INT-1:0] pins_o,
  output logic                        irq_o
);
  initial begin
    opcode_o = 8'h00;
    opcode_valid_o = 1'b0;
    pins_o = 12'h000;
    irq_o = 1'b0;
  end
  // Issues one opcode strobe; a stop is followed by two no-ops.
  task automatic exec(input logic [7:0] op);
    @(posedge clk_i);
    opcode_o <= op;
    opcode_valid_o <= 1'b1;
    @(posedge clk_i);
    opcode_valid_o <= 1'b0;
    opcode_o <= ~op;
    if (op == OPC_STOP) begin
      repeat (2) exec(OPC_NOP);
    end
  endtask
  // Toggles one external interrupt pin.
  task automatic toggle(input int i);
    @(posedge clk_i);
    pins_o[i] <= ~pins_o[i];
  endtask
  // Sets the internal interrupt level.
  task automatic irq(input logic v);
    @(posedge clk_i);
    irq_o <= v;
  endtask
endmodule

//--- tb/pwr_ctrl_checker.sv
// Port assertions for the power-down sequencer.
// Assumes it is bound to pwr_ctrl and sees only its ports.
`timescale 1ns/1ps
module pwr_ctrl_checker
  import pwr_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Inputs
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic [7:0]  opcode_i,
  input wire logic        opcode_valid_i,
  input wire logic        internal_irq_i,
  input wire logic        global_int_enable_i,
  // Outputs
  input wire logic        osc_en_o,
  input wire logic        cpu_clk_en_o,
  input wire logic        periph_clk_en_o,
  input wire logic        service_irq_o,
  input wire logic        fetch_reset_o,
  input wire logic [15:0] fetch_addr_o,
  input wire logic [1:0]  clk_div_sel_o,
  input wire logic [7:0]  port_dir_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  property p_stop_src;
    $fell(osc_en_o) |-> $past(opcode_valid_i && opcode_i == OPC_STOP);
  endproperty
  a_stop_src: assert property (p_stop_src) else $error("oscillator stopped without stop opcode");
  property p_osc_off;
    !osc_en_o |-> !cpu_clk_en_o && !periph_clk_en_o;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("clock enabled while oscillator off");
  property p_idle;
    opcode_valid_i && opcode_i == OPC_IDLE && cpu_clk_en_o |=> !cpu_clk_en_o && periph_clk_en_o && osc_en_o;
  endproperty
  a_idle: assert property (p_idle) else $error("idle entry wrong");
  property p_dir_hold;
    !cpu_clk_en_o && periph_clk_en_o && $past(!cpu_clk_en_o && periph_clk_en_o) |-> $stable(port_dir_o);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("port direction moved in idle");
  property p_div_src;
    $changed(clk_div_sel_o) |-> $past(reg_wr_i && reg_addr_i == ADDR_CLKCTL);
  endproperty
  a_div_src: assert property (p_div_src) else $error("divider changed without write");
  property p_rst_div;
    $fell(rst_i) |-> clk_div_sel_o == CLKDIV_SLOW && !cpu_clk_en_o;
  endproperty
  a_rst_div: assert property (p_rst_div) else $error("divider not slow after reset");
  property p_rst_wake;
    $fell(rst_i) |-> !cpu_clk_en_o [*2] ##[1:20] fetch_reset_o && fetch_addr_o == RESET_VECTOR;
  endproperty
  a_rst_wake: assert property (p_rst_wake) else $error("reset wake sequence wrong");
  property p_svc;
    service_irq_o |=> !service_irq_o && cpu_clk_en_o;
  endproperty
  a_svc: assert property (p_svc) else $error("service pulse wrong");
  property p_masked;
    !global_int_enable_i && !internal_irq_i && !cpu_clk_en_o && periph_clk_en_o |=> !cpu_clk_en_o;
  endproperty
  a_masked: assert property (p_masked) else $error("idle left while masked");
endmodule

bind pwr_ctrl pwr_ctrl_checker pwr_ctrl_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .opcode_i(opcode_i), .opcode_valid_i(opcode_valid_i), .internal_irq_i(internal_irq_i),
  .global_int_enable_i(global_int_enable_i), .osc_en_o(osc_en_o), .cpu_clk_en_o(cpu_clk_en_o),
  .periph_clk_en_o(periph_clk_en_o), .service_irq_o(service_irq_o), .fetch_reset_o(fetch_reset_o),
  .fetch_addr_o(fetch_addr_o), .clk_div_sel_o(clk_div_sel_o), .port_dir_o(port_dir_o));

//--- tb/pwr_ctrl_test.sv
// Self-checking bench for the power-down sequencer.
// Assumes the checker is bound and cpu_model drives opcodes and pins.
`timescale 1ns/1ps
module pwr_ctrl_test;
  import pwr_ctrl_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, wr = 1'b0, rd_s = 1'b0, gie = 1'b1, ret = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, op, dir = 8'h3C, dir_o;
  logic        opv, irq, osc, cpu, per, svc, fr;
  logic [11:0] pins, ien = 12'hFFF;
  logic [15:0] fa;
  logic [1:0]  div;
  int          n_errors = 0, n_checks = 0, cycles = 0, k;
  always #25 clk_i = ~clk_i;
  cpu_model cpu_model_inst (.clk_i(clk_i), .opcode_o(op), .opcode_valid_o(opv), .pins_o(pins), .irq_o(irq));
  pwr_ctrl pwr_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd_s), .reg_rdata_o(rdata), .opcode_i(op), .opcode_valid_i(opv), .return_from_interrupt_i(ret),
    .port_dir_i(dir), .external_interrupt_lines_i(pins), .ext_int_enable_i(ien), .internal_irq_i(irq),
    .global_int_enable_i(gie), .osc_en_o(osc), .cpu_clk_en_o(cpu), .periph_clk_en_o(per), .service_irq_o(svc),
    .fetch_reset_o(fr), .fetch_addr_o(fa), .clk_div_sel_o(div), .port_dir_o(dir_o));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_i);
    rd_s <= 1'b0;
    #1 cmp({8'h00, rdata}, {8'h00, e});
  endtask
  // Waits for the fetch pulse (sel high) or the service pulse.
  task automatic wait_hi(input bit sel);
    int n;
    n = 0;
    while ((sel ? fr : svc) !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      #1 n++;
    end
    cmp(16'(n < 200), 16'h0001);
  endtask
  task automatic reset_dut();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_hi(1'b1);
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_hi(1'b1);
    cmp(fa, RESET_VECTOR);
    rd_reg(ADDR_CLKCTL, CLKCTL_RST);
    rd_reg(8'h00, ZERO8);
    wr_reg(ADDR_DATA, 8'h5A);
    wr_reg(ADDR_BTCTL, 8'h02);
    wr_reg(ADDR_CLKCTL, 8'h18);
    cpu_model_inst.exec(OPC_STOP);
    #1 cmp({15'h0000, osc}, 16'h0001);
    for (k = 0; k < 3; k++) begin
      wr_reg(ADDR_STPKEY, STOP_KEY);
      cpu_model_inst.exec(OPC_STOP);
      #1 cmp({13'h0000, osc, cpu, per}, 16'h0000);
      if (k == 2) cpu_model_inst.irq(1'b1);
      else cpu_model_inst.toggle(k * 11);
      wait_hi(1'b0);
      cpu_model_inst.irq(1'b0);
      cmp({14'h0000, div}, 16'h0003);
      rd_reg(ADDR_STPKEY, ZERO8);
      rd_reg(ADDR_BTCTL, 8'h02);
      rd_reg(ADDR_DATA, 8'h5A);
    end
    cpu_model_inst.exec(OPC_IDLE);
    #1 cmp({13'h0000, osc, cpu, per}, 16'h0005);
    gie <= 1'b0;
    dir <= 8'hC3;
    cpu_model_inst.toggle(5);
    repeat (10) @(posedge clk_i);
    #1 cmp({15'h0000, cpu}, 16'h0000);
    cmp({8'h00, dir_o}, 16'h003C);
    gie <= 1'b1;
    ien <= 12'hFDF;
    cpu_model_inst.toggle(5);
    repeat (10) @(posedge clk_i);
    #1 cmp({15'h0000, cpu}, 16'h0000);
    ien <= 12'hFFF;
    cpu_model_inst.toggle(5);
    wait_hi(1'b0);
    cmp({14'h0000, div}, 16'h0003);
    ret <= 1'b1;
    @(posedge clk_i);
    ret <= 1'b0;
    #1 cmp({15'h0000, cpu}, 16'h0001);
    for (k = 0; k < 2; k++) begin
      wr_reg(ADDR_CLKCTL, 8'h18);
      wr_reg(ADDR_STPKEY, STOP_KEY);
      cpu_model_inst.exec(k ? OPC_STOP : OPC_IDLE);
      reset_dut();
      cmp({14'h0000, div}, 16'h0000);
      rd_reg(ADDR_DATA, 8'h5A);
      rd_reg(ADDR_STPKEY, STPKEY_RST);
    end
    close_out();
  end
endmodule
